// file: src/ossq_top.sv
`timescale 1ns/100ps
// What this block does
// - power-on clear resets the overload latch and holds the output stage off until both supplies are good.
// - a low supply puts every half-bridge in high impedance and pulls the shutdown flag low.
// - after a supply fault the block resumes on its own once all supplies are good again.
// - reset pin low forces all half-bridges to high impedance.
// - reset pin low hides all faults and holds the shutdown flag high.
// - after power-up, only a rising edge on the reset pin clears a latched overload.
// - six-channel mode follows the mode-select and reset table for bias and both groups.
// - three-channel mode switches only the first group when reset is high and mode-select low.
// - any shutdown fault pulls the shutdown flag low and the stage to high impedance.
// - thermal warning pulls the warning flag low without shutting down.
// - thermal shutdown forces high impedance and the shutdown flag, and clears by itself.
module ossq_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // detector flags and pins
    input  wire logic        gate_drive_supply_good,
    input  wire logic        vdd_supply_good,
    input  wire logic        overload_detect,
    input  wire logic        thermal_shutdown,
    input  wire logic        thermal_warning,
    input  wire logic        reset_pin_n,
    input  wire logic        bias_mode_select,
    // output stage enables, high means switching / active
    output logic             bias_precharge_control,
    output logic             group_one_enable,
    output logic             group_two_enable,
    // open-drain flags: output value is 0, oe low drives the pin
    output logic             fault_shutdown_n_out,
    output logic             fault_shutdown_n_oe_n,
    output logic             thermal_warning_n_out,
    output logic             thermal_warning_n_oe_n,
    output logic             irq,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [6:0] raw_in;
    logic [6:0] syn;
    assign raw_in = {bias_mode_select, reset_pin_n, thermal_warning, thermal_shutdown,
                     overload_detect, vdd_supply_good, gate_drive_supply_good};

    ossq_sync #(.W(7), .INIT(7'h00)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (raw_in),
        .dout    (syn)
    );

    logic gd_good, vdd_good, ovl_det, tsd, twarn, rst_pin, mode_sel;
    assign gd_good  = syn[0];
    assign vdd_good = syn[1];
    assign ovl_det  = syn[2];
    assign tsd      = syn[3];
    assign twarn    = syn[4];
    assign rst_pin  = syn[5];
    assign mode_sel = syn[6];

    // ------------------------------------------------------------
    // fault logic
    // ------------------------------------------------------------
    logic                   supplies_ok;
    logic                   rst_pin_d;
    logic                   overload_latch;
    ossq_pkg::ossq_state_type state;
    ossq_pkg::ossq_state_type next_state;
    logic                   shutdown;
    logic [31:0]            ctrl;

    assign supplies_ok = gd_good & vdd_good;
    // undervoltage, thermal or latched overload all stop the stage
    assign shutdown = !supplies_ok | tsd | overload_latch;

    // previous reset level, for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_pin_d <= 1'b0;
        end else begin
            rst_pin_d <= rst_pin;
        end
    end

    // overload latch: set by detector, cleared in power-up state or by reset rising edge
    // a detector still active at the edge wins, so the stage does not restart into a short
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overload_latch <= 1'b0;
        end else if (state == ossq_pkg::ST_POWERUP) begin
            overload_latch <= 1'b0;
        end else if (ovl_det) begin
            overload_latch <= 1'b1;
        end else if (rst_pin & !rst_pin_d) begin
            overload_latch <= 1'b0;
        end
    end

    // sequencer state
    always_comb begin
        next_state = state;
        case (state)
            ossq_pkg::ST_POWERUP: begin
                if (supplies_ok) begin
                    next_state = ossq_pkg::ST_RUN;
                end
            end
            ossq_pkg::ST_RUN: begin
                if (shutdown) begin
                    next_state = ossq_pkg::ST_FAULT;
                end
            end
            ossq_pkg::ST_FAULT: begin
                if (!shutdown) begin
                    next_state = ossq_pkg::ST_RUN;
                end
            end
            default: next_state = ossq_pkg::ST_POWERUP;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ossq_pkg::ST_POWERUP;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // output stage decode
    // ------------------------------------------------------------
    logic run_ok;
    logic next_bias, next_one, next_two;
    // combinational shutdown gate, so a fault stops the stage at the next clock edge after it is seen
    assign run_ok = (state != ossq_pkg::ST_POWERUP) & !shutdown;

    always_comb begin
        next_bias = 1'b0;
        next_one  = 1'b0;
        next_two  = 1'b0;
        if (run_ok) begin
            if (!rst_pin) begin
                next_bias = mode_sel;
            end else if (ctrl[ossq_pkg::CTRL_SIX_CH]) begin
                next_one = mode_sel;
                next_two = mode_sel;
            end else begin
                next_one = !mode_sel;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bias_precharge_control <= 1'b0;
            group_one_enable       <= 1'b0;
            group_two_enable       <= 1'b0;
        end else begin
            bias_precharge_control <= next_bias;
            group_one_enable       <= next_one;
            group_two_enable       <= next_two;
        end
    end

    // flags: reset pin low hides faults; power-up reports undervoltage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_shutdown_n_out   <= 1'b0;
            fault_shutdown_n_oe_n  <= 1'b1;
            thermal_warning_n_out  <= 1'b0;
            thermal_warning_n_oe_n <= 1'b1;
        end else begin
            fault_shutdown_n_out   <= 1'b0;
            thermal_warning_n_out  <= 1'b0;
            fault_shutdown_n_oe_n  <= !(rst_pin & shutdown);
            thermal_warning_n_oe_n <= !(rst_pin & (twarn | tsd));
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    logic [ossq_pkg::EV_W-1:0] ev_now, ev_prev, ev_rise, irq_st, irq_mk, clr_bits;
    assign ev_now  = {twarn, tsd, overload_latch, !supplies_ok};
    assign ev_rise = ev_now & ~ev_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_prev <= '0;
            irq_st  <= '0;
            irq     <= 1'b0;
        end else begin
            ev_prev <= ev_now;
            // set wins over a clear in the same cycle
            irq_st  <= (irq_st & ~clr_bits) | ev_rise;
            irq     <= |(((irq_st & ~clr_bits) | ev_rise) & irq_mk);
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic        aw_held, w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;

    assign do_write = aw_held & w_held & !s_axi_bvalid;

    function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] clr_word, mk_word;
    assign clr_word = apply_strb(32'h0, w_data, w_strb);
    assign mk_word  = apply_strb({28'h0, irq_mk}, w_data, w_strb);
    assign clr_bits = (do_write && aw_addr == ossq_pkg::ADDR_IRQ_ST)
                    ? clr_word[ossq_pkg::EV_W-1:0] : '0;

    // write channels accepted independently, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ossq_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held & !s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= !w_held & !s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == ossq_pkg::ADDR_CTRL ||
                                 aw_addr == ossq_pkg::ADDR_STATUS ||
                                 aw_addr == ossq_pkg::ADDR_IRQ_ST ||
                                 aw_addr == ossq_pkg::ADDR_IRQ_MK)
                                ? ossq_pkg::RESP_OKAY : ossq_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writable registers; status is read only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl   <= ossq_pkg::CTRL_RESET;
            irq_mk <= '0;
        end else if (do_write) begin
            if (aw_addr == ossq_pkg::ADDR_CTRL) begin
                ctrl <= apply_strb(ctrl, w_data, w_strb) & ossq_pkg::CTRL_RESET;
            end
            if (aw_addr == ossq_pkg::ADDR_IRQ_MK) begin
                irq_mk <= mk_word[ossq_pkg::EV_W-1:0];
            end
        end
    end

    // read channel, one cycle after address acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= ossq_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid & !s_axi_arready & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= ossq_pkg::RESP_OKAY;
                case (s_axi_araddr)
                    ossq_pkg::ADDR_CTRL:   s_axi_rdata <= ctrl;
                    ossq_pkg::ADDR_STATUS: s_axi_rdata <= {22'h0, state, overload_latch,
                                                           rst_pin, mode_sel, twarn, tsd,
                                                           ovl_det, vdd_good, gd_good};
                    ossq_pkg::ADDR_IRQ_ST: s_axi_rdata <= {28'h0, irq_st};
                    ossq_pkg::ADDR_IRQ_MK: s_axi_rdata <= {28'h0, irq_mk};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= ossq_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// file: pkg/ossq_pkg.sv
package ossq_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h0c;

    // ctrl fields
    localparam int CTRL_SIX_CH = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // event / status bit positions
    localparam int EV_UV   = 0;
    localparam int EV_OVL  = 1;
    localparam int EV_TSD  = 2;
    localparam int EV_TWARN = 3;
    localparam int EV_W    = 4;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_POWERUP = 2'b00,
        ST_RUN     = 2'b01,
        ST_FAULT   = 2'b10
    } ossq_state_type;

endpackage

// file: src/ossq_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser; output changes once stages two and three agree
module ossq_sync #(
    parameter int    W     = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1   <= INIT;
            s2   <= INIT;
            s3   <= INIT;
            dout <= INIT;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule

// file: verif/ossq_asserts.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// pin-level checks; eight held cycles cover sync and output flop
// ------------------------------------------------------------
module ossq_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic gate_drive_supply_good,
    input wire logic vdd_supply_good,
    input wire logic thermal_shutdown,
    input wire logic thermal_warning,
    input wire logic reset_pin_n,
    input wire logic bias_mode_select,
    input wire logic bias_precharge_control,
    input wire logic group_one_enable,
    input wire logic group_two_enable,
    input wire logic fault_shutdown_n_oe_n,
    input wire logic thermal_warning_n_oe_n
);
    logic stage_off;
    logic supply_ok;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // both channel groups in high impedance
    assign stage_off = !group_one_enable && !group_two_enable;
    assign supply_ok = gate_drive_supply_good && vdd_supply_good;

    rst_hiz_a: assert property (!reset_pin_n [*8] |-> stage_off)
        else $error("stage active with reset pin low");
    rst_hides_a: assert property (!reset_pin_n [*8] |-> fault_shutdown_n_oe_n)
        else $error("shutdown flag shown with reset pin low");
    uv_shutdown_a: assert property ((!supply_ok && reset_pin_n) [*8] |->
        stage_off && !fault_shutdown_n_oe_n)
        else $error("low supply did not shut the stage down");
    tsd_shutdown_a: assert property ((thermal_shutdown && reset_pin_n) [*8] |->
        stage_off && !fault_shutdown_n_oe_n)
        else $error("thermal shutdown did not shut the stage down");
    warn_flag_a: assert property ((thermal_warning && reset_pin_n) [*8] |->
        !thermal_warning_n_oe_n)
        else $error("warning flag not pulled low");
    bias_off_run_a: assert property ((bias_mode_select && reset_pin_n) [*8] |->
        !bias_precharge_control)
        else $error("bias active while switching");
    bias_off_low_a: assert property (!bias_mode_select [*8] |-> !bias_precharge_control)
        else $error("bias active with mode select low");
    grp_pair_a: assert property (group_two_enable |-> group_one_enable)
        else $error("second group switching alone");
endmodule

// file: verif/ossq_ctrl_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// controller model: drives mode select and reset pin
// ------------------------------------------------------------
module ossq_ctrl_model #(
    parameter int PRE   = 12,
    parameter int RWAIT = 60
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [1:0] cmd,
    input  wire logic       six_ch,
    input  wire logic       fault_shutdown_n,
    output logic            reset_pin_n = 1'h0,
    output logic            bias_mode_select = 1'h0
);
    int pre_cnt = 0;
    int wait_cnt = 0;

    // cmd 0 idle, 1 bias only, 2 precharge then run, 3 reset high with the
    // mode pin on the combination that leaves the stage off; a short rerun of
    // the precharge tail gives the rising reset edge after a latch
    always @(posedge aclk) begin
        if (!aresetn || cmd != 2'h2) begin
            reset_pin_n <= aresetn && cmd == 2'h3;
            bias_mode_select <= aresetn && (cmd == 2'h1 || (cmd == 2'h3 && !six_ch));
            pre_cnt <= 0;
            wait_cnt <= 0;
        end else if (pre_cnt < PRE) begin
            reset_pin_n <= 1'h0;
            bias_mode_select <= 1'h1;
            pre_cnt <= pre_cnt + 1;
        end else if (wait_cnt == RWAIT) begin
            pre_cnt <= PRE - 4;
            wait_cnt <= 0;
        end else begin
            reset_pin_n <= 1'h1;
            bias_mode_select <= six_ch;
            wait_cnt <= fault_shutdown_n ? 0 : wait_cnt + 1;
        end
    end
endmodule

// file: verif/ossq_top_tb.sv
`timescale 1ns/100ps
module ossq_top_tb;
    localparam int PRE = 12;
    logic aclk = 1'h0, aresetn = 1'h0, gate_drive_supply_good = 1'h0, vdd_supply_good = 1'h0;
    logic overload_detect = 1'h0, thermal_shutdown = 1'h0, thermal_warning = 1'h0;
    logic reset_pin_n, bias_mode_select, bias_precharge_control, group_one_enable;
    logic group_two_enable, fault_shutdown_n_out, fault_shutdown_n_oe_n, irq;
    logic thermal_warning_n_out, thermal_warning_n_oe_n, fault_shutdown_n, thermal_warning_n;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, six_ch = 1'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, cmd = 2'h0;
    logic [31:0] rng = 32'h2d;
    int err_total = 0, comparisons = 0, cycles = 0;

    ossq_top i_ossq_top (.*);
    ossq_ctrl_model #(.PRE(PRE), .RWAIT(60)) i_ossq_ctrl_model (.aclk(aclk),
        .aresetn(aresetn), .cmd(cmd), .six_ch(six_ch), .fault_shutdown_n(fault_shutdown_n),
        .reset_pin_n(reset_pin_n), .bias_mode_select(bias_mode_select));

    // open-drain flags with pull-ups
    assign fault_shutdown_n = fault_shutdown_n_oe_n ? 1'h1 : fault_shutdown_n_out;
    assign thermal_warning_n = thermal_warning_n_oe_n ? 1'h1 : thermal_warning_n_out;

    initial forever #2 aclk = ~aclk;

    // hang guard, well above the roughly 1100 cycles the run needs
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            results();
        end
    end

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic logic [2:0] stage();
        return {bias_precharge_control, group_one_enable, group_two_enable};
    endfunction

    // expected {bias, first group, second group} for a controller command
    function automatic logic [2:0] exp_stage(input logic [1:0] c, input logic s);
        if (c == 2'h0 || c == 2'h3) return 3'h0;
        if (c == 2'h1) return 3'h4;
        return s ? 3'h3 : 3'h2;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // ------------------------------------------------------------
    // register bus master; unmapped places answer with an error
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        check(s_axi_bresp, a > 8'h0c ? ossq_pkg::RESP_SLVERR : ossq_pkg::RESP_OKAY);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        d = s_axi_rdata;
        check(s_axi_rresp, a > 8'h0c ? ossq_pkg::RESP_SLVERR : ossq_pkg::RESP_OKAY);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        logic [31:0] d;
        logic [31:0] r;
        settle(6);
        aresetn <= 1'h1;
        cmd <= 2'h2;
        settle(PRE + 16);
        check(stage(), 3'h0);
        rd(ossq_pkg::ADDR_STATUS, d);
        check(d[9:8], ossq_pkg::ST_POWERUP);
        rd(ossq_pkg::ADDR_CTRL, d);
        check(d, ossq_pkg::CTRL_RESET);
        rd(ossq_pkg::ADDR_IRQ_MK, d);
        check(d, 32'h0);
        rd(8'h10, d);
        check(d, 32'h0);
        wr(8'h10, 32'hffffffff);
        gate_drive_supply_good <= 1'h1;
        vdd_supply_good <= 1'h1;
        // random walk over both channel modes and all pin commands
        for (int k = 0; k < 24; k++) begin
            r = xs();
            wr(ossq_pkg::ADDR_CTRL, {31'h0, r[8]});
            six_ch <= r[8];
            cmd <= r[1:0];
            settle(PRE + 16);
            check(stage(), exp_stage(cmd, six_ch));
        end
        wr(ossq_pkg::ADDR_CTRL, 32'h1);
        six_ch <= 1'h1;
        cmd <= 2'h2;
        settle(PRE + 16);
        wr(ossq_pkg::ADDR_IRQ_ST, 32'hf);
        wr(ossq_pkg::ADDR_IRQ_MK, 32'h1);
        // supply brown-out, hidden by reset pin, then self recovery
        vdd_supply_good <= 1'h0;
        settle(12);
        check(stage(), 3'h0);
        check(fault_shutdown_n, 1'h0);
        check(irq, 1'h1);
        wr(ossq_pkg::ADDR_IRQ_MK, 32'h0);
        settle(3);
        check(irq, 1'h0);
        cmd <= 2'h0;
        settle(12);
        check(fault_shutdown_n, 1'h1);
        check(stage(), 3'h0);
        cmd <= 2'h2;
        settle(PRE + 16);
        vdd_supply_good <= 1'h1;
        settle(12);
        check(stage(), 3'h3);
        check(fault_shutdown_n, 1'h1);
        wr(ossq_pkg::ADDR_IRQ_MK, 32'h1);
        wr(ossq_pkg::ADDR_IRQ_ST, 32'h1);
        settle(3);
        check(irq, 1'h0);
        // warning only, then full thermal shutdown
        thermal_warning <= 1'h1;
        settle(12);
        check({thermal_warning_n, fault_shutdown_n, stage()}, 5'h0b);
        thermal_warning <= 1'h0;
        thermal_shutdown <= 1'h1;
        settle(12);
        check({thermal_warning_n, fault_shutdown_n, stage()}, 5'h00);
        thermal_shutdown <= 1'h0;
        settle(12);
        check(stage(), 3'h3);
        // overload latches until the controller's reset edge
        overload_detect <= 1'h1;
        settle(12);
        check(fault_shutdown_n, 1'h0);
        overload_detect <= 1'h0;
        settle(30);
        check(stage(), 3'h0);
        rd(ossq_pkg::ADDR_STATUS, d);
        check({d[9:8], d[7]}, {ossq_pkg::ST_FAULT, 1'h1});
        settle(60);
        check(stage(), 3'h3);
        results();
    end
endmodule

bind ossq_top ossq_asserts i_ossq_asserts (.*);
